// ### fsc_top.sv
// fractional-n synthesizer control logic: banks, dividers, pump, trims and routing
`default_nettype none
module fsc_top
    import fsc_pkg::*;
#(
    parameter int CAL_CYCLES = int'(FSC_CAL_CYCLES)
)(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [FSC_WORD_W-1:0] config_word_one,  // [R23]
    input  wire logic                  ref_div_bypass,
    input  wire logic                  full_duplex_sel,
    input  wire logic                  mode_pin,
    input  wire logic                  chip_enable_pin,
    input  wire fsc_bank_s             bank1_cfg,
    input  wire fsc_bank_s             bank2_cfg,
    input  wire logic                  bank_load,
    input  wire logic                  pump_low_range,
    input  wire logic                  bw_corr_en,
    input  wire logic [FSC_CP_W-1:0]   bw_corr_code,
    input  wire logic [1:0]            band_select_factor,
    input  wire logic                  active_filter_en,
    input  wire logic                  detector_polarity,
    input  wire logic                  osc_keep_alive,
    input  wire logic [3:0]            osc_cap_coarse,
    input  wire logic                  osc_cap_fine,
    input  wire logic [3:0]            mixer1_bias_code,
    input  wire logic [3:0]            mixer2_bias_code,
    input  wire logic                  trim_load,
    input  wire logic                  fb_cycle,
    output logic [2:0]                 ref_ratio,
    output logic                       ref_div_pulse,
    output logic                       mixer1_lo_en,
    output logic                       mixer2_lo_en,
    output logic                       bank2_active,
    output logic                       prescaler_plus1,
    output logic [FSC_INT_W-1:0]       int_ratio,
    output logic [FSC_CP_W-1:0]        pump_code,
    output logic [7:0]                 pump_current_ua,
    output logic [1:0]                 band_factor_out,
    output logic                       opamp_en,
    output logic                       loop_filter_pin_hiz,
    output logic                       polarity_out,
    output logic                       osc_run,
    output logic [3:0]                 osc_cap_coarse_out,
    output logic                       osc_cap_fine_out,
    output logic [3:0]                 mixer1_bias_out,
    output logic [3:0]                 mixer2_bias_out,
    output logic                       band_cal_busy
);
    //==========================================================
    // state
    typedef struct packed {
        fsc_bank_s             b1;
        fsc_bank_s             b2;
        logic [2:0]            ratio;
        logic [2:0]            rcnt;
        logic                  rpulse;
        logic                  m1;
        logic                  m2;
        logic                  sel2;
        logic [FSC_FRAC_W-1:0] acc;
        logic                  plus1;
        logic [FSC_INT_W-1:0]  nint;
        logic [FSC_CP_W-1:0]   cp;
        logic [7:0]            icp;
        logic [1:0]            bsf;
        logic                  opa;
        logic                  hiz;
        logic                  pol;
        logic                  osc;
        logic [3:0]            xct;
        logic                  xfs;
        logic [3:0]            mb1;
        logic [3:0]            mb2;
        logic                  en_q;
        fsc_cal_e              cal;
        logic [10:0]           ccnt;
        logic                  busy;
    } fsc_state_s;

    fsc_state_s st_q;
    fsc_state_s st_d;
    fsc_bank_s  act;
    logic [2:0] prog_ratio;
    logic [FSC_FRAC_W:0] sum;
    logic [12:0] prod;
    logic [12:0] quot;
    logic [FSC_CP_W-1:0] cp_sel;

    localparam logic [10:0] CAL_LAST = 11'(CAL_CYCLES - 1);

    //==========================================================
    // next state
    always_comb
    begin
        st_d = st_q;

        //======================================================
        // bank capture and routing
        if (bank_load)
        begin
            st_d.b1 = bank1_cfg;  // [R04]
            st_d.b2 = bank2_cfg;  // [R04]
        end
        act = mode_pin ? st_q.b2 : st_q.b1;  // [R05]
        st_d.sel2 = mode_pin;  // [R05]
        st_d.m1 = full_duplex_sel | ~mode_pin;  // [R05] [R06]
        st_d.m2 = full_duplex_sel | mode_pin;  // [R05] [R06]

        //======================================================
        // reference divider
        // ratio code kept apart from bypass so the code survives a bypass toggle
        prog_ratio = config_word_one[FSC_RDIV_HI:FSC_RDIV_LO];  // [R02]
        if (prog_ratio < FSC_RDIV_MIN)
            prog_ratio = FSC_RDIV_MIN;
        st_d.ratio = ref_div_bypass ? FSC_RDIV_ONE : prog_ratio;  // [R01] [R07]
        st_d.rpulse = 1'b0;
        if (st_q.rcnt + 3'h1 >= st_q.ratio)
        begin
            st_d.rcnt = 3'h0;
            st_d.rpulse = 1'b1;  // [R01] [R07]
        end
        else
            st_d.rcnt = st_q.rcnt + 3'h1;

        //======================================================
        // feedback divider and fraction
        st_d.nint = act.int_divider;  // [R08]
        // one accumulator step per divided feedback edge; carry picks n+1
        sum = {1'b0, st_q.acc} + {1'b0, act.frac_upper, act.frac_lower};  // [R09] [R10]
        if (fb_cycle)
        begin
            st_d.acc = sum[FSC_FRAC_W-1:0];  // [R24]
            st_d.plus1 = sum[FSC_FRAC_W];  // [R11] [R24]
        end

        //======================================================
        // charge pump
        cp_sel = bw_corr_en ? bw_corr_code : act.pump_current_code;  // [R15]
        st_d.cp = cp_sel;  // [R13]
        prod = 13'(cp_sel) * 13'(pump_low_range ? FSC_ICP_LOW : FSC_ICP_FULL);  // [R13] [R14]
        quot = prod / FSC_CP_DIV;  // [R14]
        st_d.icp = quot[7:0];

        //======================================================
        // loop filter and oscillator
        st_d.bsf = band_select_factor;
        st_d.opa = active_filter_en;  // [R17]
        st_d.hiz = ~active_filter_en;  // [R17]
        st_d.pol = detector_polarity;
        st_d.osc = chip_enable_pin | osc_keep_alive;  // [R19]

        //======================================================
        // crystal and mixer trims
        if (trim_load)
        begin
            st_d.xct = osc_cap_coarse;  // [R20]
            st_d.xfs = osc_cap_fine;  // [R20]
            st_d.mb1 = mixer1_bias_code;  // [R21]
            st_d.mb2 = mixer2_bias_code;  // [R21]
        end

        //======================================================
        // band selection timing
        st_d.en_q = chip_enable_pin;
        unique case (st_q.cal)
            FSC_IDLE:
            begin
                if (chip_enable_pin && !st_q.en_q)
                begin
                    st_d.cal = FSC_CAL;  // [R22]
                    st_d.ccnt = 11'h000;
                end
            end
            FSC_CAL:
            begin
                // a fresh enable edge restarts the search count from zero
                if (chip_enable_pin && !st_q.en_q)
                    st_d.ccnt = 11'h000;  // [R22]
                else if (st_q.ccnt >= CAL_LAST)
                    st_d.cal = FSC_IDLE;
                else
                    st_d.ccnt = st_q.ccnt + 11'h001;
            end
            default:
                st_d.cal = FSC_IDLE;
        endcase
        // busy kept as its own flop so the output needs no decode
        st_d.busy = (st_d.cal == FSC_CAL);  // [R22]
    end

    //==========================================================
    // registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.b1.pump_current_code <= FSC_CP_RST;  // [R13]
            st_q.b2.pump_current_code <= FSC_CP_RST;  // [R13]
            st_q.cp <= FSC_CP_RST;
            st_q.icp <= FSC_ICP_FULL;
            st_q.ratio <= FSC_RDIV_ONE;
            st_q.m1 <= 1'b1;
            st_q.hiz <= 1'b1;  // [R17]
            st_q.xct <= FSC_OSC_CAP_COARSE_RST;  // [R20]
            st_q.mb1 <= FSC_MIX_RST;  // [R21]
            st_q.mb2 <= FSC_MIX_RST;  // [R21]
            st_q.cal <= FSC_IDLE;
        end
        else
            st_q <= st_d;
    end

    //==========================================================
    // outputs
    assign ref_ratio           = st_q.ratio;
    assign ref_div_pulse       = st_q.rpulse;
    assign mixer1_lo_en        = st_q.m1;
    assign mixer2_lo_en        = st_q.m2;
    assign bank2_active        = st_q.sel2;
    assign prescaler_plus1     = st_q.plus1;
    assign int_ratio           = st_q.nint;
    assign pump_code           = st_q.cp;
    assign pump_current_ua     = st_q.icp;
    assign band_factor_out     = st_q.bsf;
    assign opamp_en            = st_q.opa;
    assign loop_filter_pin_hiz = st_q.hiz;  // [R17]
    assign polarity_out        = st_q.pol;
    assign osc_run             = st_q.osc;
    assign osc_cap_coarse_out  = st_q.xct;
    assign osc_cap_fine_out    = st_q.xfs;
    assign mixer1_bias_out     = st_q.mb1;
    assign mixer2_bias_out     = st_q.mb2;
    assign band_cal_busy       = st_q.busy;  // [R22]

    //==========================================================
    // checks
    sequence en_rise_s;
        chip_enable_pin && !st_q.en_q;
    endsequence

    sequence cal_window_s;
        band_cal_busy [*8];
    endsequence

    bypass_ratio_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R01]
        ref_div_bypass |=> ref_ratio == FSC_RDIV_ONE)
        else $error("bypass did not give ratio one");
    ratio_code_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R02]
        (!ref_div_bypass && config_word_one[FSC_RDIV_HI:FSC_RDIV_LO] >= FSC_RDIV_MIN)
            |=> ref_ratio == $past(config_word_one[FSC_RDIV_HI:FSC_RDIV_LO]))
        else $error("ratio does not follow divider code");
    bank_route_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R05]
        !full_duplex_sel |=> (mixer1_lo_en != mixer2_lo_en) && (mixer2_lo_en == $past(mode_pin)))
        else $error("half duplex routing wrong");
    duplex_both_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R06]
        full_duplex_sel |=> mixer1_lo_en && mixer2_lo_en)
        else $error("full duplex must drive both mixers");
    filter_hiz_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
        loop_filter_pin_hiz == !opamp_en)
        else $error("filter pin must float when op-amp off");
    osc_keep_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
        (osc_keep_alive && !chip_enable_pin) |=> osc_run)
        else $error("oscillator stopped under keep-alive");
    pump_scale_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        (!bw_corr_en && !pump_low_range && act.pump_current_code == FSC_CP_RST) |=> pump_current_ua == FSC_ICP_FULL)
        else $error("full code must give full scale");
    cal_start_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R22]
        en_rise_s |=> cal_window_s)
        else $error("band selection not started on enable");

    //==========================================================
    // divider and routing checks
    ratio_clamp_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R02]
        (!ref_div_bypass && config_word_one[FSC_RDIV_HI:FSC_RDIV_LO] < FSC_RDIV_MIN) |=> ref_ratio == FSC_RDIV_MIN)
        else $error("low divider codes must clamp to two");
    bypass_pulse_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R01]
        ref_ratio == FSC_RDIV_ONE |=> ref_div_pulse)
        else $error("ratio one must pulse every cycle");
    pulse_gap_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R07]
        (ref_div_pulse && ref_ratio != FSC_RDIV_ONE) |=> !ref_div_pulse)
        else $error("divided reference pulsed twice in a row");
    bank_sel_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R05]
        1'b1 |=> bank2_active == $past(mode_pin))
        else $error("active bank must follow mode pin");
    mix1_only_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R05]
        (!full_duplex_sel && !mode_pin) |=> mixer1_lo_en && !mixer2_lo_en)
        else $error("mode low half duplex must drive mixer one only");
    mix2_only_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R05]
        (!full_duplex_sel && mode_pin) |=> !mixer1_lo_en && mixer2_lo_en)
        else $error("mode high half duplex must drive mixer two only");
    bank_take_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R04]
        bank_load |=> st_q.b1 == $past(bank1_cfg) && st_q.b2 == $past(bank2_cfg))
        else $error("banks not captured on load");
    bank1_int_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R08]
        !mode_pin |=> int_ratio == $past(st_q.b1.int_divider))
        else $error("integer ratio must come from bank one");
    bank2_int_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R04]
        mode_pin |=> int_ratio == $past(st_q.b2.int_divider))
        else $error("integer ratio must come from bank two");

    //==========================================================
    // pump and fraction checks
    carry_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R24]
        !fb_cycle |=> $stable(prescaler_plus1))
        else $error("modulus choice moved without a feedback cycle");
    corr_code_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
        bw_corr_en |=> pump_code == $past(bw_corr_code))
        else $error("correction code not applied to pump");
    pump_bound_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        1'b1 |=> pump_current_ua <= FSC_ICP_FULL)
        else $error("pump current above full scale");

    //==========================================================
    // trim, filter and band checks
    trim_take_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R20]
        trim_load |=> osc_cap_coarse_out == $past(osc_cap_coarse) && osc_cap_fine_out == $past(osc_cap_fine))
        else $error("crystal trims not captured");
    trim_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R20]
        !trim_load |=> $stable(osc_cap_coarse_out) && $stable(osc_cap_fine_out))
        else $error("crystal trims moved without load");
    bias_take_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R21]
        trim_load |=> mixer1_bias_out == $past(mixer1_bias_code) && mixer2_bias_out == $past(mixer2_bias_code))
        else $error("mixer bias codes not captured");
    bias_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R21]
        !trim_load |=> $stable(mixer1_bias_out) && $stable(mixer2_bias_out))
        else $error("mixer bias codes moved without load");
    osc_off_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
        (!osc_keep_alive && !chip_enable_pin) |=> !osc_run)
        else $error("oscillator must stop without enable or keep-alive");
    filter_on_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
        active_filter_en |=> opamp_en && !loop_filter_pin_hiz)
        else $error("active filter must enable op-amp");
    pol_follow_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
        1'b1 |=> polarity_out == $past(detector_polarity))
        else $error("detector polarity not passed on");
    band_factor_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        1'b1 |=> band_factor_out == $past(band_select_factor))
        else $error("band-select factor not passed on");
    cal_quiet_a : assert property (@(posedge ref_clk) disable iff (!rst_n) // [R22]
        (!band_cal_busy && !(chip_enable_pin && !st_q.en_q)) |=> !band_cal_busy)
        else $error("band selection started without enable edge");
endmodule : fsc_top
`default_nettype wire

// ### fsc_pkg.sv
// package of constants and carrier types for the fractional-n synthesizer control block
// Notes on behaviour
// R01 - bypass low uses programmed reference divider; bypass high divides by one
// R02 - three-bit divider code at bits 15..13 selects ratio 2 to 7
// R03 - controller keeps phase detector frequency at or below 52 MHz
// R04 - two independent banks; bank one serves mixer one, bank two mixer two
// R05 - mode pin picks bank; full duplex off enables only matching mixer
// R06 - full duplex drives oscillator to both mixers for either bank
// R07 - oscillator settles at divider value times reference over ratio 1..7
// R08 - ten-bit integer field is the integer part of feedback ratio
// R09 - numerator is fraction of divide value scaled by 16777216
// R10 - fraction split: upper field holds msbs, lower field the lsbs
// R11 - dual-modulus prescaler with fractional sequence gives average ratio
// R12 - controller keeps fractional divide value between 15 and 511
// R13 - reset pump code 31, low range 0: 120 uA; low range 30 uA
// R14 - pump current is full scale times code over 31
// R15 - bandwidth correction uses measured gain code instead; off by default
// R16 - controller sets band-select factor 00 when integer below 28
// R17 - active filter bit enables op-amp; low disables with high impedance
// R18 - controller sets polarity 1 for active filter, 0 for passive
// R19 - keep-alive keeps crystal oscillator running while enable low
// R20 - coarse trim 4 bits reset 0100; fine trim 1 bit reset 0
// R21 - separate four-bit bias code per mixer, default 100
// R22 - every enable rising edge starts band selection with active bank
// R23 - serial access is seven-bit address then sixteen-bit data
// R24 - sequence generator updates modulus once per feedback cycle, active bank numerator
`default_nettype none
package fsc_pkg;
    //==========================================================
    // widths and fields
    localparam int          FSC_INT_W      = 10;
    localparam int          FSC_FRAC_W     = 24;
    localparam int          FSC_FUP_W      = 16;
    localparam int          FSC_FLO_W      = 8;
    localparam int          FSC_CP_W       = 5;
    localparam int          FSC_WORD_W     = 16;
    localparam int          FSC_RDIV_HI    = 15;
    localparam int          FSC_RDIV_LO    = 13;
    localparam int          FSC_CAL_W      = 7;
    //==========================================================
    // reset values and figures
    localparam logic [4:0]  FSC_CP_RST     = 5'h1f;
    localparam logic [3:0]  FSC_OSC_CAP_COARSE_RST  = 4'h4;
    localparam logic [3:0]  FSC_MIX_RST    = 4'h4;
    localparam logic [2:0]  FSC_RDIV_ONE   = 3'h1;
    localparam logic [2:0]  FSC_RDIV_MIN   = 3'h2;
    localparam logic [7:0]  FSC_ICP_FULL   = 8'h78;
    localparam logic [7:0]  FSC_ICP_LOW    = 8'h1e;
    localparam logic [12:0] FSC_CP_DIV     = 13'h001f;
    localparam logic [10:0] FSC_CAL_CYCLES = 11'h05dc;
    typedef struct packed {
        logic [FSC_INT_W-1:0] int_divider;
        logic [FSC_FUP_W-1:0] frac_upper;
        logic [FSC_FLO_W-1:0] frac_lower;
        logic [FSC_CP_W-1:0]  pump_current_code;
    } fsc_bank_s;
    typedef enum logic [1:0] {
        FSC_IDLE = 2'b01,
        FSC_CAL  = 2'b10
    } fsc_cal_e;
endpackage : fsc_pkg
`default_nettype wire

// ### fsc_ctrl_model.sv
// controller model: bank contents, band factor and polarity choices
`default_nettype none
module fsc_ctrl_model
    import fsc_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      load_req,
    input  wire logic      mode_pin,
    input  wire logic      active_filter_en,
    output var fsc_bank_s  bank1_cfg,
    output var fsc_bank_s  bank2_cfg,
    output logic           bank_load,
    output logic [1:0]     band_select_factor,
    output logic           detector_polarity
);
    //==========================================================
    // bank contents
    // bank one: divide 75.2508, fraction split upper then lower
    assign bank1_cfg = '{10'h04b, 16'h4036, 8'hcc, 5'h10};
    // bank two: integer 20 with half fraction, still above the floor of 15
    assign bank2_cfg = '{10'h014, 16'h8000, 8'h00, 5'h1f};
    always @(posedge ref_clk)
        bank_load <= load_req;
    //==========================================================
    // settings that follow the active bank and filter
    // small integer ratios need factor 00 or band selection misbehaves
    assign band_select_factor = ((mode_pin ? bank2_cfg.int_divider : bank1_cfg.int_divider) < 10'h01c)
                                ? 2'h0 : 2'h1;
    assign detector_polarity = active_filter_en;
endmodule : fsc_ctrl_model
`default_nettype wire

// ### test_fsc_top.sv
// self-checking bench for the synthesizer control block
`default_nettype none
module test_fsc_top
    import fsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic [6:0] i; logic [6:0] o; } fsc_row_s;
    //==========================================================
    // signals
    logic ref_clk = 1'b0;
    logic rst_n, ref_div_bypass, full_duplex_sel, mode_pin, chip_enable_pin, load_req;
    logic pump_low_range, bw_corr_en, active_filter_en, osc_keep_alive, osc_cap_fine, trim_load, fb_cycle;
    logic [15:0] config_word_one;
    logic [4:0] bw_corr_code, pump_code;
    logic [3:0] osc_cap_coarse, mixer1_bias_code, mixer2_bias_code;
    fsc_bank_s bank1_cfg, bank2_cfg;
    logic bank_load, detector_polarity, ref_div_pulse, mixer1_lo_en, mixer2_lo_en, bank2_active;
    logic [1:0] band_select_factor, band_factor_out;
    logic [2:0] ref_ratio;
    logic [9:0] int_ratio;
    logic [7:0] pump_current_ua;
    logic prescaler_plus1, opamp_en, loop_filter_pin_hiz, polarity_out, osc_run, osc_cap_fine_out, band_cal_busy;
    logic [3:0] osc_cap_coarse_out, mixer1_bias_out, mixer2_bias_out;
    int n_fail = 0, num_checks = 0, cyc = 0, k;
    // mode fd bypass code[3] filter -> ratio[3] mixer1 mixer2 bank2 opamp
    fsc_row_s rows [6] = '{'{7'h05, 7'h29}, '{7'h4e, 7'h76}, '{7'h3b, 7'h1d},
                           '{7'h66, 7'h3e}, '{7'h01, 7'h29}, '{7'h5d, 7'h17}};

    always #50 ref_clk = ~ref_clk;

    fsc_ctrl_model i_fsc_ctrl_model (
        .ref_clk, .load_req, .mode_pin, .active_filter_en, .bank1_cfg, .bank2_cfg, .bank_load,
        .band_select_factor, .detector_polarity
    );
    // short calibration keeps the busy-window test quick
    fsc_top #(.CAL_CYCLES(10)) i_fsc_top (
        .ref_clk, .rst_n, .config_word_one, .ref_div_bypass, .full_duplex_sel, .mode_pin,
        .chip_enable_pin, .bank1_cfg, .bank2_cfg, .bank_load, .pump_low_range, .bw_corr_en,
        .bw_corr_code, .band_select_factor, .active_filter_en, .detector_polarity, .osc_keep_alive,
        .osc_cap_coarse, .osc_cap_fine, .mixer1_bias_code, .mixer2_bias_code, .trim_load, .fb_cycle,
        .ref_ratio, .ref_div_pulse, .mixer1_lo_en, .mixer2_lo_en, .bank2_active, .prescaler_plus1,
        .int_ratio, .pump_code, .pump_current_ua, .band_factor_out, .opamp_en, .loop_filter_pin_hiz,
        .polarity_out, .osc_run, .osc_cap_coarse_out, .osc_cap_fine_out, .mixer1_bias_out,
        .mixer2_bias_out, .band_cal_busy
    );
    //==========================================================
    // helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask : tick
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    // whole run needs about two hundred cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            close_out();
        end
    end
    //==========================================================
    // sequence
    initial
    begin
        {rst_n, config_word_one, ref_div_bypass, full_duplex_sel, mode_pin, chip_enable_pin, load_req} = '0;
        {pump_low_range, bw_corr_en, bw_corr_code, active_filter_en, osc_keep_alive} = '0;
        {osc_cap_coarse, osc_cap_fine, mixer1_bias_code, mixer2_bias_code, trim_load, fb_cycle} = '0;
        tick(12);
        chk({pump_code, pump_current_ua}, {5'h1f, 8'h78});
        chk({osc_cap_coarse_out, osc_cap_fine_out}, {4'h4, 1'b0});
        chk({mixer1_bias_out, mixer2_bias_out, band_cal_busy, osc_run}, 10'h110);
        rst_n = 1'b1;
        load_req = 1'b1;
        tick(1);
        load_req = 1'b0;
        tick(2);
        for (k = 0; k < 6; k++)
        begin
            {mode_pin, full_duplex_sel, ref_div_bypass, config_word_one[15:13], active_filter_en} = rows[k].i;
            tick(2);
            chk({ref_ratio, mixer1_lo_en, mixer2_lo_en, bank2_active, opamp_en}, rows[k].o);
            chk({loop_filter_pin_hiz, polarity_out, int_ratio},
                {~active_filter_en, active_filter_en, mode_pin ? 10'h014 : 10'h04b});
            chk({band_factor_out, pump_code}, {mode_pin ? 2'h0 : 2'h1, mode_pin ? 5'h1f : 5'h10});
        end
        // divide by 7: pulse spacing
        {config_word_one[15:13], ref_div_bypass, mode_pin} = 5'h1c;
        tick(3);
        for (k = 0; k < 20 && ref_div_pulse !== 1'b1; k++)
            tick(1);
        k = 0;
        do
        begin
            tick(1);
            k++;
        end while (ref_div_pulse !== 1'b1 && k < 20);
        chk(24'(k), 24'h7);
        // pump scaling, low range and bandwidth correction
        pump_low_range = 1'b1;
        tick(2);
        chk(pump_current_ua, 8'h0f);
        pump_low_range = 1'b0;
        tick(2);
        chk(pump_current_ua, 8'h3d);
        {bw_corr_en, bw_corr_code} = 6'h25;
        tick(2);
        chk({pump_code, pump_current_ua}, {5'h05, 8'h13});
        bw_corr_en = 1'b0;
        // trims captured on load, held afterwards
        {osc_cap_coarse, osc_cap_fine, mixer1_bias_code, mixer2_bias_code, trim_load} = 14'h3e2b;
        tick(1);
        {osc_cap_coarse, trim_load} = 5'h00;
        tick(2);
        chk({osc_cap_coarse_out, osc_cap_fine_out, mixer1_bias_out, mixer2_bias_out}, 13'h1f15);
        osc_keep_alive = 1'b1;
        tick(2);
        chk(osc_run, 1'b1);
        osc_keep_alive = 1'b0;
        tick(2);
        chk(osc_run, 1'b0);
        // band selection window after enable rises
        chip_enable_pin = 1'b1;
        tick(2);
        chk({band_cal_busy, osc_run}, 2'h3);
        k = 0;
        while (band_cal_busy === 1'b1 && k < 40)
        begin
            tick(1);
            k++;
        end
        chk(24'(k), 24'h9);
        // carries of bank one fraction over 64 feedback cycles
        k = 0;
        repeat (64)
        begin
            fb_cycle = 1'b1;
            tick(1);
            fb_cycle = 1'b0;
            tick(1);
            if (prescaler_plus1 === 1'b1)
                k++;
        end
        chk(24'(k), 24'h10);
        // mid-run reset brings pump, trims and filter pin back
        rst_n = 1'b0;
        tick(1);
        chk({pump_code, osc_cap_coarse_out, mixer1_bias_out, loop_filter_pin_hiz}, 14'h3e89);
        close_out();
    end
endmodule : test_fsc_top
`default_nettype wire
